// ### design/flc_config_regs.sv
/*
 * Configuration register bank of an LED flash driver behind an
 * I2C-compatible serial port, with trigger handling, flags, flash timer
 * and internal indicator pattern generator.
 * Assumes scl/sda and the trigger pins are synchronous to clk_i and that
 * the pad logic resolves the open-drain sda from sda_oe_o.
 */
// Functional notes
// R01 - Indicator period is rise plus fall plus two pulse times.
// R02 - Active time is period times count; blank is active times blank count.
// R03 - Two 3-bit torch ramp fields, up and down, 16 ms to 2.048 s.
// R04 - Strobe level usage: flash follows pin; edge usage: internal timing.
// R05 - Per-pin polarity bits for strobe, torch, transmit; default active high.
// R06 - Transmit event drops current to torch level, or off when level bit 0.
// R07 - Off setting shuts down only during flash, not torch or indicator.
// R08 - Such events in torch/indicator set flag and lock mode bits until read.
// R09 - Host should clear transmit enable before reading flags when events recur.
// R10 - Input voltage flash monitoring only when its enable bit is set.
// R11 - Thermistor normal mode cuts current; monitor mode only reports.
// R12 - Indicator source: internal pattern at 0, torch pin at 1.
// R13 - 2-bit inductor limit field, top bits, default 3.1 A code.
// R14 - Flash ramp field default 1.024 ms; time-out 100 to 800 ms, default 300.
// R15 - 3-bit torch current code in bits 6:4, default 000.
// R16 - 4-bit flash current code in bits 3:0, default 1111.
// R17 - Mode bits select standby/indicator/torch/flash; no pin trigger means host start.
// R18 - Faults need flag read-back to resume; flags set again if still present.
// R19 - Reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
module flc_config_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h30,
    parameter int MS_TICKS = flc_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic strobe_pin_i,
    input wire logic torch_pin_i,
    input wire logic tx_pin_i,
    input wire logic thermistor_trip_i,
    input wire logic input_voltage_flash_monitor_trip_i,
    input wire logic uvlo_i,
    input wire logic ovp_i,
    input wire logic short_i,
    input wire logic overtemp_i,
    input wire logic [7:0] ind_rise_i,
    input wire logic [7:0] ind_fall_i,
    input wire logic [7:0] ind_pulse_i,
    input wire logic [2:0] ind_periods_i,
    input wire logic [3:0] ind_blanks_i,
    output flc_pkg::flc_drive_t drive_o,
    output flc_pkg::flc_ramp_t ramp_o,
    output logic input_voltage_flash_monitor_o,
    output logic thermistor_monitor_o,
    output logic pass_only_o,
    output logic precharge_o
);
    import flc_pkg::*;

    if (MS_TICKS < 2) begin : g_chk
        $error("MS_TICKS must be at least 2");
    end

    // Registers
    flc_torch_ramp_t torch_ramp;
    flc_trig_cfg_t trig_cfg;
    flc_flash_cfg_t flash_cfg;
    flc_current_t current;
    flc_enable_t enable;
    flc_flags_t flags;
    logic mode_lock;
    logic fault_hold;

    // Serial port state
    flc_sp_state_t sp_state;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [3:0] bitc;
    logic [7:0] ptr;
    logic nack;

    wire logic scl_rise = scl_i & ~scl_q;
    wire logic scl_fall = ~scl_i & scl_q;
    wire logic start_cond = scl_i & scl_q & sda_q & ~sda_i;
    wire logic stop_cond = scl_i & scl_q & ~sda_q & sda_i;
    wire logic byte_done = scl_fall & (bitc == 4'h8);
    wire logic addr_match = (shift[7:1] == DEV_ADDR);
    wire logic wr_stb = (sp_state == SP_WR) & byte_done;
    wire logic rd_done = (sp_state == SP_RD) & byte_done;
    wire logic flags_read = rd_done & (ptr == REG_FLAGS);

    logic [7:0] rdata;
    always_comb begin
        case (ptr)
            REG_TORCH_RAMP: rdata = torch_ramp;
            REG_TRIG_CFG: rdata = trig_cfg;
            REG_FLASH_CFG: rdata = flash_cfg;
            REG_CURRENT: rdata = current;
            REG_ENABLE: rdata = enable;
            REG_FLAGS: rdata = flags;
            default: rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Serial port sequencer
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sp_state <= SP_IDLE;
            shift <= 8'h00;
            bitc <= 4'h0;
            ptr <= 8'h00;
            nack <= 1'b0;
        end else if (start_cond) begin
            sp_state <= SP_ADDR;
            bitc <= 4'h0;
        end else if (stop_cond) begin
            sp_state <= SP_IDLE;
        end else begin
            case (sp_state)
                SP_IDLE: begin
                    bitc <= 4'h0;
                end
                SP_ADDR, SP_PTR, SP_WR: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_i};
                        bitc <= bitc + 4'h1;
                    end else if (byte_done) begin
                        bitc <= 4'h0;
                        if (sp_state == SP_ADDR) begin
                            sp_state <= addr_match ? SP_ADDR_ACK : SP_IDLE;
                            nack <= shift[0];
                        end else if (sp_state == SP_PTR) begin
                            ptr <= shift;
                            sp_state <= SP_PTR_ACK;
                        end else begin
                            ptr <= ptr + 8'h01;
                            sp_state <= SP_WR_ACK;
                        end
                    end
                end
                SP_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (nack) begin
                            shift <= rdata;
                            sp_state <= SP_RD;
                        end else begin
                            sp_state <= SP_PTR;
                        end
                    end
                end
                SP_PTR_ACK, SP_WR_ACK: begin
                    if (scl_fall) begin
                        sp_state <= SP_WR;
                    end
                end
                SP_RD: begin
                    if (scl_rise) begin
                        bitc <= bitc + 4'h1;
                    end else if (byte_done) begin
                        bitc <= 4'h0;
                        ptr <= ptr + 8'h01;
                        sp_state <= SP_RD_ACK;
                    end else if (scl_fall) begin
                        shift <= {shift[6:0], 1'b0};
                    end
                end
                SP_RD_ACK: begin
                    if (scl_rise) begin
                        nack <= sda_i;
                    end else if (scl_fall) begin
                        shift <= rdata;
                        sp_state <= nack ? SP_IDLE : SP_RD;
                    end
                end
                default: sp_state <= SP_IDLE;
            endcase
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = (sp_state == SP_ADDR_ACK) | (sp_state == SP_PTR_ACK) | (sp_state == SP_WR_ACK)
        | ((sp_state == SP_RD) & ~shift[7]);

    // Trigger pins
    logic strobe_act;
    logic strobe_rise;
    logic torch_act;
    logic tx_act;
    logic tx_rise;
    logic torch_pin_act;

    flc_pin_cond u_strobe (
        .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(strobe_pin_i),
        .act_high_i(trig_cfg.strobe_act_high), .enable_i(enable.strobe_en),
        .active_o(strobe_act), .rise_o(strobe_rise)
    );
    flc_pin_cond u_torch (
        .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(torch_pin_i),
        .act_high_i(trig_cfg.torch_act_high), .enable_i(1'b1),
        .active_o(torch_pin_act), .rise_o()
    );
    flc_pin_cond u_tx (
        .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(tx_pin_i),
        .act_high_i(trig_cfg.tx_act_high), .enable_i(enable.tx_en),
        .active_o(tx_act), .rise_o(tx_rise)
    );
    assign torch_act = torch_pin_act & enable.torch_en;

    // Millisecond tick shared by the flash timer and the indicator
    logic [31:0] ms_cnt;
    wire logic ms_tick = (ms_cnt == 32'(MS_TICKS - 1));
    always_ff @(posedge clk_i) begin
        if (!rstn_i || ms_tick) begin
            ms_cnt <= 32'h0;
        end else begin
            ms_cnt <= ms_cnt + 32'h1;
        end
    end

    // Mode decode
    wire flc_mode_t mode = enable.operating_mode_bits;
    // Decoded from the byte being written: the mode bits only land on this edge
    wire flc_enable_t en_wdata = shift;
    wire logic host_go = (sp_state == SP_WR) & byte_done & (ptr == REG_ENABLE)
        & (en_wdata.operating_mode_bits == MODE_FLASH) & ~en_wdata.strobe_en & ~mode_lock; // [R17]
    wire logic in_flash = (mode == MODE_FLASH);
    wire logic tx_hit = tx_act;
    wire logic tx_cut = tx_hit & ~trig_cfg.tx_to_torch;
    wire logic ntc_cut = enable.ntc_en & thermistor_trip_i & ~trig_cfg.ntc_report; // [R11]

    // Flash run and time-out
    logic flash_run;
    logic [9:0] flash_ms;
    wire logic [9:0] flash_limit = 10'(({7'h0, flash_cfg.timeout} + 10'h1) * TIMEOUT_STEP_MS); // [R14]
    wire logic timed_out = flash_run & (flash_ms >= flash_limit);
    wire logic flash_start = ~fault_hold & ~flash_run & (host_go
        | in_flash & enable.strobe_en & (trig_cfg.strobe_level ? strobe_act : strobe_rise)); // [R17]
    wire logic level_end = enable.strobe_en & trig_cfg.strobe_level & ~strobe_act; // [R04]

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            flash_run <= 1'b0;
            flash_ms <= 10'h0;
        end else if (flash_start) begin
            flash_run <= 1'b1;
            flash_ms <= 10'h0;
        end else if (timed_out || level_end || !in_flash || fault_hold) begin
            flash_run <= 1'b0;
        end else if (flash_run && ms_tick) begin
            flash_ms <= flash_ms + 10'h1;
        end
    end

    // Internal indicator pattern
    wire logic [9:0] period_len = {2'b0, ind_rise_i} + {2'b0, ind_fall_i} + {1'b0, ind_pulse_i, 1'b0}; // [R01]
    wire logic [9:0] on_len = {2'b0, ind_rise_i} + {2'b0, ind_pulse_i} + {2'b0, ind_fall_i};
    wire logic [12:0] active_len = 13'(period_len) * 13'(ind_periods_i); // [R02]
    wire logic [16:0] blank_len = 17'(active_len) * 17'(ind_blanks_i); // [R02]
    logic in_blank;
    logic [9:0] ind_pos;
    logic [2:0] ind_pcnt;
    logic [16:0] ind_bcnt;
    wire logic ind_mode = (mode == MODE_INDICATOR) & ~trig_cfg.ind_external;

    always_ff @(posedge clk_i) begin
        if (!rstn_i || !ind_mode) begin
            in_blank <= 1'b0;
            ind_pos <= 10'h0;
            ind_pcnt <= 3'h0;
            ind_bcnt <= 17'h0;
        end else if (ms_tick && !in_blank) begin
            if (ind_pos + 10'h1 >= period_len) begin
                ind_pos <= 10'h0;
                if (ind_pcnt + 3'h1 >= ind_periods_i) begin
                    ind_pcnt <= 3'h0;
                    in_blank <= (blank_len != 17'h0);
                end else begin
                    ind_pcnt <= ind_pcnt + 3'h1;
                end
            end else begin
                ind_pos <= ind_pos + 10'h1;
            end
        end else if (ms_tick) begin
            if (ind_bcnt + 17'h1 >= blank_len) begin
                ind_bcnt <= 17'h0;
                in_blank <= 1'b0;
            end else begin
                ind_bcnt <= ind_bcnt + 17'h1;
            end
        end
    end

    wire logic ind_pat = ~in_blank & (ind_periods_i != 3'h0) & (ind_pos < on_len);
    wire logic ind_src = trig_cfg.ind_external ? torch_pin_act : ind_pat; // [R12]

    // Drive request
    wire logic torch_on = (mode == MODE_TORCH) & (~enable.torch_en | torch_act); // [R17]
    wire logic ind_on = (mode == MODE_INDICATOR) & ind_src;
    wire logic flash_on = flash_run & ~tx_cut; // [R06] [R07]
    wire logic next_on = ~fault_hold & ~ntc_cut & (flash_on | torch_on | ind_on);
    wire logic [3:0] next_level = (flash_run & ~tx_hit) ? current.flash_code : {1'b0, current.torch_code}; // [R06]

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            drive_o <= '0;
        end else begin
            drive_o.on <= next_on;
            drive_o.mode <= fault_hold ? MODE_STANDBY : mode;
            drive_o.level <= next_level; // [R15] [R16]
        end
    end

    assign ramp_o = '{torch_up: torch_ramp.ramp_up, torch_down: torch_ramp.ramp_down,
        flash_ramp: flash_cfg.flash_ramp, ilim: flash_cfg.ilim}; // [R03] [R13] [R14]
    assign input_voltage_flash_monitor_o = trig_cfg.input_voltage_flash_monitor_en; // [R10]
    assign thermistor_monitor_o = enable.ntc_en & trig_cfg.ntc_report;
    assign pass_only_o = enable.pass_only;
    assign precharge_o = enable.precharge;

    // Flags: a new event beats the read that clears
    wire logic lock_evt = tx_rise & ~trig_cfg.tx_to_torch & ((mode == MODE_TORCH) | (mode == MODE_INDICATOR)); // [R08]
    flc_flags_t flag_set;
    assign flag_set = '{tx_event: tx_rise, ntc_trip: enable.ntc_en & thermistor_trip_i,
        input_voltage_flash_monitor: trig_cfg.input_voltage_flash_monitor_en & input_voltage_flash_monitor_trip_i, uvlo: uvlo_i, ovp: ovp_i, short_fault: short_i,
        overtemp: overtemp_i, timeout: timed_out}; // [R10] [R18]
    wire logic fault_evt = uvlo_i | ovp_i | short_i | overtemp_i;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            flags <= '0;
            mode_lock <= 1'b0;
            fault_hold <= 1'b0;
        end else begin
            flags <= (flags & ~{8{flags_read}}) | flag_set; // [R18]
            mode_lock <= (mode_lock & ~flags_read) | lock_evt; // [R08]
            fault_hold <= (fault_hold & ~flags_read) | fault_evt; // [R18]
        end
    end

    // Register writes
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            torch_ramp <= RST_TORCH_RAMP;
            trig_cfg <= RST_TRIG_CFG;
            flash_cfg <= RST_FLASH_CFG;
            current <= RST_CURRENT;
            enable <= RST_ENABLE;
        end else begin
            if (wr_stb && ptr == REG_TORCH_RAMP) begin
                torch_ramp <= shift & MASK_TORCH_RAMP; // [R03] [R19]
            end
            if (wr_stb && ptr == REG_TRIG_CFG) begin
                trig_cfg <= shift; // [R04] [R05]
            end
            if (wr_stb && ptr == REG_FLASH_CFG) begin
                flash_cfg <= shift; // [R13] [R14]
            end
            if (wr_stb && ptr == REG_CURRENT) begin
                current <= shift & MASK_CURRENT; // [R19]
            end
            if (timed_out) begin
                enable.operating_mode_bits <= MODE_STANDBY;
            end else if (wr_stb && ptr == REG_ENABLE) begin
                enable[7:2] <= shift[7:2];
                if (!mode_lock) begin
                    enable.operating_mode_bits <= flc_mode_t'(shift[1:0]); // [R08]
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_flag_read;
        flags_read ##1 1'b1;
    endsequence

    a_tx_flag_set : assert property (tx_rise |=> flags.tx_event) else $error("tx flag not set"); // [R08]
    a_mode_locked : assert property (mode_lock && wr_stb && ptr == REG_ENABLE && !timed_out
        |=> mode == $past(mode)) else $error("locked mode bits changed"); // [R08]
    a_flash_tx_off : assert property (flash_run && tx_cut |=> !drive_o.on)
        else $error("flash not cut by tx event"); // [R06]
    a_torch_tx_keep : assert property (mode == MODE_TORCH && !enable.torch_en && !fault_hold && !ntc_cut
        && tx_cut |=> drive_o.on) else $error("torch shut down by tx event"); // [R07]
    a_input_voltage_flash_monitor_gated : assert property (!trig_cfg.input_voltage_flash_monitor_en && !flags.input_voltage_flash_monitor |=> !flags.input_voltage_flash_monitor)
        else $error("input_voltage_flash_monitor flag set while disabled"); // [R10]
    a_ntc_cut : assert property (ntc_cut |=> !drive_o.on) else $error("thermistor cut ignored"); // [R11]
    a_rsvd_zero : assert property (torch_ramp.reserved_bit == 2'b00 && current.reserved_bit == 1'b0)
        else $error("reserved bit set"); // [R19]
    a_flash_timeout : assert property (timed_out |=> !flash_run && flags.timeout && mode == MODE_STANDBY)
        else $error("flash time-out not handled"); // [R14]
    a_fault_holds : assert property (fault_hold && !flags_read |=> fault_hold)
        else $error("fault released without read"); // [R18]
    a_fault_clear : assert property (fault_hold && !fault_evt && !uvlo_i ##0 s_flag_read |-> !fault_hold)
        else $error("fault not released by read"); // [R18]
    a_blank_dark : assert property (ind_mode && in_blank |=> !drive_o.on)
        else $error("indicator lit during blank"); // [R02]
    a_level_follow : assert property (flash_run && level_end && !flash_start |=> !flash_run)
        else $error("level strobe end ignored"); // [R04]

endmodule : flc_config_regs

// ### design/flc_pkg.sv
/*
 * Shared constants and types for the LED flash driver configuration block:
 * register offsets, reset values, write masks, field layouts, modes, timing.
 * Assumes a 100 MHz core clock and byte-wide registers behind the serial port.
 */
package flc_pkg;

    // Register offsets
    localparam logic [7:0] REG_TORCH_RAMP = 8'h06;
    localparam logic [7:0] REG_TRIG_CFG = 8'h07;
    localparam logic [7:0] REG_FLASH_CFG = 8'h08;
    localparam logic [7:0] REG_CURRENT = 8'h09;
    localparam logic [7:0] REG_ENABLE = 8'h0a;
    localparam logic [7:0] REG_FLAGS = 8'h0b;

    // Reset values
    localparam logic [7:0] RST_TORCH_RAMP = 8'h00;
    localparam logic [7:0] RST_TRIG_CFG = 8'h78;
    localparam logic [7:0] RST_FLASH_CFG = 8'hd2;
    localparam logic [7:0] RST_CURRENT = 8'h0f;
    localparam logic [7:0] RST_ENABLE = 8'h00;

    // Writable bits; the rest are reserved and stay zero
    localparam logic [7:0] MASK_TORCH_RAMP = 8'h3f;
    localparam logic [7:0] MASK_CURRENT = 8'h7f;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ONE_MS_NS = 1000000;
    localparam int MS_CYCLES = (ONE_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_STEP_MS = 100;

    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_INDICATOR = 2'b01,
        MODE_TORCH = 2'b10,
        MODE_FLASH = 2'b11
    } flc_mode_t;

    typedef struct packed {
        logic [1:0] reserved_bit;
        logic [2:0] ramp_up;
        logic [2:0] ramp_down;
    } flc_torch_ramp_t;

    typedef struct packed {
        logic strobe_level;
        logic strobe_act_high;
        logic torch_act_high;
        logic tx_act_high;
        logic tx_to_torch;
        logic input_voltage_flash_monitor_en;
        logic ntc_report;
        logic ind_external;
    } flc_trig_cfg_t;

    typedef struct packed {
        logic [1:0] ilim;
        logic [2:0] flash_ramp;
        logic [2:0] timeout;
    } flc_flash_cfg_t;

    typedef struct packed {
        logic reserved_bit;
        logic [2:0] torch_code;
        logic [3:0] flash_code;
    } flc_current_t;

    typedef struct packed {
        logic ntc_en;
        logic tx_en;
        logic strobe_en;
        logic torch_en;
        logic precharge;
        logic pass_only;
        flc_mode_t operating_mode_bits;
    } flc_enable_t;

    typedef struct packed {
        logic tx_event;
        logic ntc_trip;
        logic input_voltage_flash_monitor;
        logic uvlo;
        logic ovp;
        logic short_fault;
        logic overtemp;
        logic timeout;
    } flc_flags_t;

    // Drive request towards the analog current source
    typedef struct packed {
        logic on;
        flc_mode_t mode;
        logic [3:0] level;
    } flc_drive_t;

    typedef struct packed {
        logic [2:0] torch_up;
        logic [2:0] torch_down;
        logic [2:0] flash_ramp;
        logic [1:0] ilim;
    } flc_ramp_t;

    typedef enum logic [8:0] {
        SP_IDLE = 9'b000000001,
        SP_ADDR = 9'b000000010,
        SP_ADDR_ACK = 9'b000000100,
        SP_PTR = 9'b000001000,
        SP_PTR_ACK = 9'b000010000,
        SP_WR = 9'b000100000,
        SP_WR_ACK = 9'b001000000,
        SP_RD = 9'b010000000,
        SP_RD_ACK = 9'b100000000
    } flc_sp_state_t;

endpackage : flc_pkg

// ### design/flc_pin_cond.sv
/*
 * Trigger pin conditioner: applies the programmed polarity and enable,
 * and flags the cycle in which the pin becomes active.
 * Assumes the pin is already synchronous to clk_i.
 */
`timescale 1ns/1ps
module flc_pin_cond (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    input wire logic act_high_i,
    input wire logic enable_i,
    output logic active_o,
    output logic rise_o
);
    import flc_pkg::*;

    logic prev;
    wire logic level = ~(pin_i ^ act_high_i) & enable_i; // [R05]

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign active_o = level;
    assign rise_o = level & ~prev;

    a_rise_once : assert property (@(posedge clk_i) disable iff (!rstn_i)
        rise_o |=> !rise_o) else $error("rise pulse longer than one cycle"); // [R05]

endmodule : flc_pin_cond

// ### dv/flc_host_model.sv
/* Host on the serial port: bit, byte, register write and read tasks.
   Assumes sda has a pull-up and the device pulls low while sda_oe_i is high. */
`timescale 1ns/1ps
module flc_host_model (
    input wire logic clk_i,
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic drv = 1'b1;
    initial scl_o = 1'b1;
    // Pull-up unless a party pulls low
    assign sda_o = drv & ~sda_oe_i;
    task automatic hp;
        repeat (4) @(negedge clk_i);
    endtask : hp
    task automatic bit_io(input logic b, output logic r);
        hp();
        drv = b;
        hp();
        scl_o = 1'b1;
        hp();
        r = sda_o;
        scl_o = 1'b0;
    endtask : bit_io
    task automatic start;
        hp();
        drv = 1'b1;
        hp();
        scl_o = 1'b1;
        hp();
        drv = 1'b0;
        hp();
        scl_o = 1'b0;
    endtask : start
    task automatic stop;
        hp();
        drv = 1'b0;
        hp();
        scl_o = 1'b1;
        hp();
        drv = 1'b1;
        hp();
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(m, ack);
    endtask : xfer
    task automatic wr(input logic [6:0] adr, input logic [7:0] ptr, input logic [7:0] d, output logic ack);
        logic [7:0] q;
        logic a;
        start();
        xfer({adr, 1'b0}, 1'b1, q, ack);
        xfer(ptr, 1'b1, q, a);
        xfer(d, 1'b1, q, a);
        stop();
    endtask : wr
    // Pointer set by a data-less write, then repeated start and one read with NACK
    task automatic rd(input logic [6:0] adr, input logic [7:0] ptr, output logic [7:0] d);
        logic a;
        start();
        xfer({adr, 1'b0}, 1'b1, d, a);
        xfer(ptr, 1'b1, d, a);
        start();
        xfer({adr, 1'b1}, 1'b1, d, a);
        xfer(8'hff, 1'b1, d, a);
        stop();
    endtask : rd
endmodule : flc_host_model

// ### dv/flc_config_regs_bench.sv
/* Self-checking bench: reference register copies, random writes, trigger cases.
   Assumes the host model and the package are compiled first. */
`timescale 1ns/1ps
module flc_config_regs_bench;
    import flc_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic scl;
    logic sda;
    logic sda_oe;
    logic tx = 1'b0;
    logic input_voltage_flash_monitor;
    logic a;
    logic [7:0] v;
    logic [7:0] flt = '0;
    logic [7:0] tm = 8'h02;
    flc_drive_t drive;
    flc_ramp_t ramp;
    logic [7:0] mdl [4] = '{8'h00, 8'h78, 8'hd2, 8'h0f};
    logic [7:0] msk [4] = '{8'h3f, 8'hff, 8'hff, 8'h7f};
    int n_fail = 0;
    int checked = 0;
    int lit;
    always #5 clk_i = ~clk_i;
    flc_host_model i_flc_host_model (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    flc_config_regs #(.MS_TICKS(20)) i_flc_config_regs (
        .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .strobe_pin_i(flt[6]), .torch_pin_i(flt[7]), .tx_pin_i(tx), .thermistor_trip_i(flt[0]),
        .input_voltage_flash_monitor_trip_i(flt[1]), .uvlo_i(flt[2]), .ovp_i(flt[3]), .short_i(flt[4]), .overtemp_i(flt[5]),
        .ind_rise_i(tm), .ind_fall_i(tm), .ind_pulse_i(tm), .ind_periods_i(tm[2:0]), .ind_blanks_i(tm[3:0]),
        .drive_o(drive), .ramp_o(ramp), .input_voltage_flash_monitor_o(input_voltage_flash_monitor),
        .thermistor_monitor_o(), .pass_only_o(), .precharge_o());
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic put(input logic [7:0] ptr, input logic [7:0] d);
        i_flc_host_model.wr(7'h30, ptr, d, a);
        check(a, 1'b0);
    endtask : put
    // Level is only meaningful while the drive is on
    task automatic pulse_tx(input logic [15:0] exp);
        tx = 1'b1;
        repeat (2) @(negedge clk_i);
        check({drive.on, drive.on ? drive.level : 4'h0}, exp);
        tx = 1'b0;
        @(negedge clk_i);
    endtask : pulse_tx
    initial begin
        #600us;
        n_fail++;
        end_of_test();
    end
    initial begin
        void'($urandom(74811));
        repeat (4) @(negedge clk_i);
        rstn_i = 1'b1;
        i_flc_host_model.wr(7'h31, 8'h09, 8'hff, a);
        check(a, 1'b1);
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 4; i++) begin
                i_flc_host_model.rd(7'h30, 8'h06 + 8'(i), v);
                check(v, mdl[i]);
            end
            check({ramp.torch_up, ramp.torch_down, ramp.flash_ramp, ramp.ilim}, {mdl[0][5:0], mdl[2][5:3], mdl[2][7:6]});
            check(input_voltage_flash_monitor, mdl[1][2]);
            tm = 8'($urandom);
            for (int i = 0; i < 4; i++) begin
                v = 8'($urandom);
                put(8'h06 + 8'(i), v);
                mdl[i] = v & msk[i];
            end
        end
        put(8'h07, 8'h78);
        put(8'h09, 8'h35);
        put(8'h0a, 8'h43);
        @(negedge clk_i);
        check({drive.on, drive.level}, 16'h15);
        pulse_tx(16'h13);
        put(8'h07, 8'h70);
        pulse_tx(16'h00);
        put(8'h0a, 8'h42);
        @(negedge clk_i);
        check({drive.on, drive.level}, 16'h13);
        pulse_tx(16'h13);
        put(8'h0a, 8'h00);
        check(drive.on, 1'b1);
        i_flc_host_model.rd(7'h30, 8'h0b, v);
        check(v[7], 1'b1);
        put(8'h0a, 8'h00);
        @(negedge clk_i);
        check(drive.on, 1'b0);
        put(8'h0a, 8'h02);
        flt = 8'h04;
        @(negedge clk_i);
        flt = 8'h00;
        repeat (2) @(negedge clk_i);
        check(drive.on, 1'b0);
        i_flc_host_model.rd(7'h30, 8'h0b, v);
        check(v, 8'h10);
        check(drive.on, 1'b1);
        put(8'h0a, 8'h82);
        flt = 8'h01;
        repeat (2) @(negedge clk_i);
        check(drive.on, 1'b0);
        put(8'h07, 8'h7a);
        check(drive.on, 1'b1);
        flt = 8'h00;
        // Rise, fall, pulse 1 ms, one period, one blank: 8 ms cycle, 3 ms lit
        tm = 8'h01;
        put(8'h0a, 8'h01);
        repeat (200) @(negedge clk_i);
        lit = 0;
        repeat (320) begin
            @(negedge clk_i);
            lit += drive.on;
        end
        check(lit, 2 * 3 * 20);
        put(8'h08, 8'hc0);
        put(8'h0a, 8'h03);
        repeat (1900) @(negedge clk_i);
        check(drive.on, 1'b1);
        repeat (200) @(negedge clk_i);
        check({drive.on, drive.mode}, 3'b000);
        i_flc_host_model.rd(7'h30, 8'h0b, v);
        check(v[0], 1'b1);
        end_of_test();
    end
endmodule : flc_config_regs_bench
